// ### core/fcr_device.sv
// Purpose: Flash array with mapping, locking, guarded enables and auto operations.
// Assumes: Host end on the same mclk; nmiPin is asynchronous.
// Notes: Programming only clears bits, as real flash cells do.
`timescale 1ns/1ps
`default_nettype none
module fcr_device
	import fcr_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	fcr_if.device lnk,
	input wire logic nmiPin,
	input wire logic wdtEvent,
	input wire logic [1:0] bootSrc,
	input wire logic extValid,
	input wire logic extErase,
	input wire logic [15:0] extAddr,
	input wire logic [7:0] extData,
	input wire logic [15:0] rdAddr,
	output logic [7:0] rdData,
	output logic rdHit,
	output logic wdtFreeze,
	output logic dataMapped,
	output logic area2On,
	output logic memWait
);
	logic [7:0] mem [NUM_WORDS];
	logic [7:0] flash_mode_reg_zero_reg;
	logic [7:0] flash_mode_reg_one_reg;
	logic [7:0] pm1_reg;
	logic [7:0] cm_reg;
	logic [7:0] second_area_control_reg_reg;
	logic [7:0] lock_reg;
	logic armA_reg;
	logic armB_reg;
	logic nmiS1_reg;
	logic nmiS2_reg;
	logic nmiOld_reg;
	logic busy_reg;
	logic erase_reg;
	logic [3:0] blk_reg;
	logic [3:0] word_reg;
	logic [7:0] data_reg;
	logic [7:0] cnt_reg;
	logic done_reg;
	logic refused_reg;
	logic aborted_reg;
	logic nmiEdge;
	logic abortNow;
	logic selFmr0;
	logic reqValid;
	logic reqErase;
	logic [15:0] reqAddr;
	logic [7:0] reqData;
	logic [4:0] reqDec;
	logic reqLocked;
	logic [7:0] lockVec;
	fcr_src_t src;

	// Decode a CPU address into {hit, block}; word index is the low nibble.
	function automatic logic [4:0] decode(input logic [15:0] a, input logic mapOn,
		input logic a2Off);
		logic [4:0] r;
		r = 5'h00;
		if (mapOn && a >= DATA_BASE) begin
			r = {1'b1, a[12] ? BLK_DATA_B : BLK_DATA_A};
		end else if (a[15]) begin
			r = {2'b10, a[14:12]};
		end else if (a[15:12] == AREA2_PAGE && !a2Off) begin
			r = {1'b1, BLK_AREA2};
		end
		return r;
	endfunction : decode

	// The NMI pin is asynchronous, so it passes two flops before the edge detector.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			nmiS1_reg <= 1'b0;
			nmiS2_reg <= 1'b0;
			nmiOld_reg <= 1'b0;
		end else begin
			nmiS1_reg <= nmiPin;
			nmiS2_reg <= nmiS1_reg;
			nmiOld_reg <= nmiS2_reg;
		end
	end

	assign nmiEdge = nmiS2_reg && !nmiOld_reg;
	// NMI or watchdog halts RAM mode
	assign abortNow = nmiEdge || (wdtEvent && !flash_mode_reg_one_reg[EW1_BIT]);
	assign selFmr0 = lnk.regWr && lnk.regSel == SEL_FLASH_MODE_REG_ZERO;
	assign src = fcr_src_t'(bootSrc);

	always_comb begin
		if (src == FCR_SRC_CPU) begin
			reqValid = lnk.cmdValid && flash_mode_reg_zero_reg[ENA_BIT];
			reqErase = lnk.cmdErase;
			reqAddr = lnk.cmdAddr;
			reqData = lnk.cmdData;
		end else begin
			reqValid = extValid;
			reqErase = extErase;
			reqAddr = extAddr;
			reqData = extData;
		end
	end

	// Per-block lock decode; only area one blocks carry a lock bit.
	genvar gi;
	generate
		for (gi = 0; gi < AREA1_BLKS; gi++) begin : gLock
			assign lockVec[gi] = lock_reg[gi] && reqDec[3:0] == 4'(gi);
		end
	endgenerate

	assign reqDec = decode(reqAddr, pm1_reg[MAP_BIT], second_area_control_reg_reg[DIS_BIT]);
	assign reqLocked = |lockVec;

	// Flash mode register zero with its guarded enables.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			flash_mode_reg_zero_reg <= 8'h00;
			armA_reg <= 1'b0;
			armB_reg <= 1'b0;
		end else if (abortNow) begin
			flash_mode_reg_zero_reg <= 8'h00;
			armA_reg <= 1'b0;
			armB_reg <= 1'b0;
		end else if (selFmr0) begin
			if (!lnk.regWdata[ENA_BIT]) begin
				flash_mode_reg_zero_reg[ENA_BIT] <= 1'b0;
				armA_reg <= 1'b1;
			end else if (armA_reg) begin
				flash_mode_reg_zero_reg[ENA_BIT] <= 1'b1;
				armA_reg <= 1'b0;
			end
			if (!lnk.regWdata[ENB_BIT]) begin
				flash_mode_reg_zero_reg[ENB_BIT] <= 1'b0;
				armB_reg <= 1'b1;
			end else if (armB_reg) begin
				flash_mode_reg_zero_reg[ENB_BIT] <= 1'b1;
				armB_reg <= 1'b0;
			end
		end
	end

	// Flash mode register one; also cleared by the forced reset.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			flash_mode_reg_one_reg <= 8'h00;
		end else if (abortNow) begin
			flash_mode_reg_one_reg <= 8'h00;
		end else if (lnk.regWr && lnk.regSel == SEL_FLASH_MODE_REG_ONE) begin
			flash_mode_reg_one_reg <= lnk.regWdata;
		end
	end

	// Mapping, clock and lock registers; not touched by an abort.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pm1_reg <= 8'h00;
			cm_reg <= CM_RST;
			second_area_control_reg_reg <= SECOND_AREA_CONTROL_REG_RST;
			lock_reg <= LOCK_RST;
		end else if (lnk.regWr) begin
			case (lnk.regSel)
				SEL_PM1: pm1_reg <= lnk.regWdata;
				SEL_CM: cm_reg <= lnk.regWdata;
				SEL_SECOND_AREA_CONTROL_REG: second_area_control_reg_reg <= lnk.regWdata;
				SEL_LOCK: lock_reg <= lnk.regWdata;
				default: ;
			endcase
		end
	end

	// Auto program/erase sequencer; a new request is taken only while idle.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			busy_reg <= 1'b0;
			erase_reg <= 1'b0;
			blk_reg <= 4'h0;
			word_reg <= 4'h0;
			data_reg <= 8'h00;
			cnt_reg <= 8'h00;
			done_reg <= 1'b0;
			refused_reg <= 1'b0;
			aborted_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			refused_reg <= 1'b0;
			aborted_reg <= 1'b0;
			if (busy_reg) begin
				if (abortNow) begin
					busy_reg <= 1'b0;
					aborted_reg <= 1'b1;
				end else if (cnt_reg == 8'd1) begin
					busy_reg <= 1'b0;
					done_reg <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg - 8'd1;
				end
			end else if (reqValid) begin
				if (!reqDec[4] || reqLocked) begin
					refused_reg <= 1'b1;
				end else begin
					busy_reg <= 1'b1;
					erase_reg <= reqErase;
					blk_reg <= reqDec[3:0];
					word_reg <= reqAddr[3:0];
					data_reg <= reqData;
					cnt_reg <= reqErase ? ERASE_CYCLES : PROG_CYCLES;
				end
			end
		end
	end

	// The array changes only at the last cycle of an operation that was not aborted.
	always_ff @(posedge mclk) begin
		if (busy_reg && !abortNow && cnt_reg == 8'd1) begin
			if (erase_reg) begin
				for (int i = 0; i < WORDS_PER_BLK; i++) begin
					mem[{blk_reg, 4'(i)}] <= 8'hff;
				end
			end else begin
				mem[{blk_reg, word_reg}] <= mem[{blk_reg, word_reg}] & data_reg;
			end
		end
	end

	// Registered read port; a miss reads as all ones.
	always_ff @(posedge mclk) begin
		logic [4:0] d;
		d = decode(rdAddr, pm1_reg[MAP_BIT], second_area_control_reg_reg[DIS_BIT]);
		if (!rst_n) begin
			rdData <= 8'hff;
			rdHit <= 1'b0;
		end else begin
			rdHit <= d[4];
			rdData <= d[4] ? mem[{d[3:0], rdAddr[3:0]}] : 8'hff;
		end
	end

	// Status back to the host and out to the system.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wdtFreeze <= 1'b0;
			dataMapped <= 1'b0;
			area2On <= 1'b0;
			memWait <= 1'b0;
		end else begin
			wdtFreeze <= busy_reg && flash_mode_reg_one_reg[EW1_BIT] && !(abortNow || cnt_reg == 8'd1);
			dataMapped <= pm1_reg[MAP_BIT];
			area2On <= !second_area_control_reg_reg[DIS_BIT];
			memWait <= pm1_reg[WAIT_BIT];
		end
	end

	assign lnk.cmdBusy = busy_reg;
	assign lnk.cmdDone = done_reg;
	assign lnk.cmdRefused = refused_reg;
	assign lnk.cmdAborted = aborted_reg;
	assign lnk.modeEw1 = flash_mode_reg_one_reg[EW1_BIT];
	assign lnk.rewriteOn = flash_mode_reg_zero_reg[ENA_BIT];
endmodule : fcr_device
`default_nettype wire

// ### core/fcr_host.sv
// Purpose: Rewrite control program as hardware, driven by software over AXI4-Lite.
// Assumes: isrActive is a level from the interrupt logic on mclk.
// Notes: One rewrite at a time; a halted rewrite is rerun once.
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fcr_host
	import fcr_pkg::*;
#(
	parameter logic [3:0] SELF_PAGE = 4'hf
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic isrActive,
	output logic irqHold,
	output logic dmaHold,
	output logic fetchGuard,
	fcr_if.host lnk
);
	typedef enum {H_IDLE, H_CLK, H_PM1, H_MODE, H_EN0, H_EN1, H_CMD, H_WAIT, H_EXIT,
		H_RETRY, H_MAPW, H_PRGW, H_LOCKW} fcr_hst_t;
	fcr_hst_t st_reg;
	logic [7:0] waddr_reg;
	logic [31:0] wdat_reg;
	logic haveAw_reg;
	logic haveW_reg;
	logic [3:0] ctrl_reg;
	logic [15:0] addr_reg;
	logic [7:0] data_reg;
	logic [15:0] map_reg;
	logic [2:0] stat_reg;
	logic startPend_reg;
	logic mapPend_reg;
	logic retried_reg;
	logic doWrite;
	logic startOk;

	assign doWrite = haveAw_reg && haveW_reg && !bvalid;
	assign startOk = !(ctrl_reg[2] && addr_reg[15:12] == SELF_PAGE) && (ctrl_reg[2] || ctrl_reg[3]);

	// Write channels are taken independently; the response follows both.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			haveAw_reg <= 1'b0;
			haveW_reg <= 1'b0;
			waddr_reg <= 8'h00;
			wdat_reg <= 32'h0000_0000;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				haveAw_reg <= 1'b1;
				waddr_reg <= awaddr;
			end
			if (wvalid && wready) begin
				haveW_reg <= 1'b1;
				wdat_reg <= wdata;
			end
			if (doWrite) begin
				haveAw_reg <= 1'b0;
				haveW_reg <= 1'b0;
				bvalid <= 1'b1;
				bresp <= (waddr_reg > OFS_MAP) ? RESP_SLVERR : RESP_OKAY;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	assign awready = !haveAw_reg && !bvalid;
	assign wready = !haveW_reg && !bvalid;

	// Software registers; wstrb is ignored since every field is written whole.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctrl_reg <= 4'h0;
			addr_reg <= 16'h0000;
			data_reg <= 8'hff;
			map_reg <= 16'h0001;
			startPend_reg <= 1'b0;
			mapPend_reg <= 1'b0;
		end else begin
			if (st_reg == H_IDLE && startPend_reg) begin
				startPend_reg <= 1'b0;
			end else if (st_reg == H_IDLE && mapPend_reg) begin
				mapPend_reg <= 1'b0;
			end
			if (doWrite) begin
				case (waddr_reg)
					OFS_CTRL: begin
						ctrl_reg <= {wdat_reg[3:1], 1'b0};
						startPend_reg <= wdat_reg[0];
					end
					OFS_ADDR: addr_reg <= wdat_reg[15:0];
					OFS_DATA: data_reg <= wdat_reg[7:0];
					OFS_MAP: begin
						map_reg <= wdat_reg[15:0];
						mapPend_reg <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

	// Read channel; status shows busy, done, refused and aborted.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp <= RESP_OKAY;
			case (araddr)
				OFS_CTRL: rdata <= {28'h0000000, ctrl_reg};
				OFS_ADDR: rdata <= {16'h0000, addr_reg};
				OFS_DATA: rdata <= {24'h000000, data_reg};
				OFS_STAT: rdata <= {28'h0000000, stat_reg, st_reg != H_IDLE};
				OFS_MAP: rdata <= {16'h0000, map_reg};
				default: begin
					rdata <= 32'h0000_0000;
					rresp <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	assign arready = !rvalid;

	// Rewrite sequence with its link strobes.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_reg <= H_IDLE;
			stat_reg <= 3'h0;
			retried_reg <= 1'b0;
			lnk.regWr <= 1'b0;
			lnk.regSel <= SEL_FLASH_MODE_REG_ZERO;
			lnk.regWdata <= 8'h00;
			lnk.cmdValid <= 1'b0;
			lnk.cmdErase <= 1'b0;
			lnk.cmdAddr <= 16'h0000;
			lnk.cmdData <= 8'h00;
		end else begin
			lnk.regWr <= 1'b0;
			lnk.cmdValid <= 1'b0;
			case (st_reg)
				H_IDLE: begin
					retried_reg <= 1'b0;
					if (startPend_reg) begin
						stat_reg <= startOk ? 3'h0 : 3'h2;
						st_reg <= startOk ? H_CLK : H_IDLE;
					end else if (mapPend_reg) begin
						st_reg <= H_MAPW;
					end
				end
				H_CLK: begin
					lnk.regWr <= 1'b1;
					lnk.regSel <= SEL_CM;
					lnk.regWdata <= CLK_DIV_SAFE;
					st_reg <= H_PM1;
				end
				H_PM1, H_MAPW: begin
					lnk.regWr <= 1'b1;
					lnk.regSel <= SEL_PM1;
					lnk.regWdata <= 8'(1 << WAIT_BIT) | {7'h00, map_reg[0]};
					st_reg <= st_reg == H_PM1 ? H_MODE : H_PRGW;
				end
				H_PRGW: begin
					lnk.regWr <= 1'b1;
					lnk.regSel <= SEL_SECOND_AREA_CONTROL_REG;
					lnk.regWdata <= {7'h00, map_reg[1]};
					st_reg <= H_LOCKW;
				end
				H_LOCKW: begin
					lnk.regWr <= 1'b1;
					lnk.regSel <= SEL_LOCK;
					lnk.regWdata <= map_reg[15:8];
					st_reg <= H_IDLE;
				end
				H_MODE: begin
					lnk.regWr <= 1'b1;
					lnk.regSel <= SEL_FLASH_MODE_REG_ONE;
					lnk.regWdata <= {6'h00, ctrl_reg[2], 1'b0};
					st_reg <= H_EN0;
				end
				H_EN0, H_EN1: begin
					lnk.regWr <= 1'b1;
					lnk.regSel <= SEL_FLASH_MODE_REG_ZERO;
					lnk.regWdata <= st_reg == H_EN0 ? 8'h00 : 8'h06;
					st_reg <= st_reg == H_EN0 ? H_EN1 : H_CMD;
				end
				H_CMD: begin
					lnk.cmdValid <= 1'b1;
					lnk.cmdErase <= ctrl_reg[1];
					lnk.cmdAddr <= addr_reg;
					lnk.cmdData <= data_reg;
					st_reg <= H_WAIT;
				end
				H_WAIT: begin
					if (lnk.cmdAborted) begin
						st_reg <= retried_reg ? H_EXIT : H_RETRY;
						stat_reg[2] <= retried_reg;
					end else if (lnk.cmdDone || lnk.cmdRefused) begin
						stat_reg <= {1'b0, lnk.cmdRefused, lnk.cmdDone};
						st_reg <= H_EXIT;
					end
				end
				H_RETRY: begin
					retried_reg <= 1'b1;
					st_reg <= isrActive ? H_RETRY : H_CLK;
				end
				H_EXIT: begin
					lnk.regWr <= 1'b1;
					lnk.regSel <= SEL_FLASH_MODE_REG_ZERO;
					lnk.regWdata <= 8'h00;
					st_reg <= H_IDLE;
				end
				default: st_reg <= H_IDLE;
			endcase
		end
	end

	// Guard outputs for the CPU core around the rewrite.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			irqHold <= 1'b0;
			dmaHold <= 1'b0;
			fetchGuard <= 1'b0;
		end else begin
			irqHold <= st_reg == H_EN0 || st_reg == H_EN1 ||
				(ctrl_reg[2] && (st_reg == H_CMD || st_reg == H_WAIT));
			dmaHold <= st_reg == H_EN0 || st_reg == H_EN1;
			fetchGuard <= !ctrl_reg[2] && st_reg != H_IDLE && st_reg != H_MAPW &&
				st_reg != H_PRGW && st_reg != H_LOCKW;
		end
	end
endmodule : fcr_host
`default_nettype wire

// ### shared/fcr_if.sv
// Purpose: Link between the rewrite host and the flash controller.
// Assumes: Both ends run on mclk.
// Notes: Register writes and commands are one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
interface fcr_if (
	input wire logic mclk
);
	logic regWr;
	logic [2:0] regSel;
	logic [7:0] regWdata;
	logic cmdValid;
	logic cmdErase;
	logic [15:0] cmdAddr;
	logic [7:0] cmdData;
	logic cmdBusy;
	logic cmdDone;
	logic cmdRefused;
	logic cmdAborted;
	logic modeEw1;
	logic rewriteOn;
	modport device (input regWr, regSel, regWdata, cmdValid, cmdErase, cmdAddr, cmdData,
		output cmdBusy, cmdDone, cmdRefused, cmdAborted, modeEw1, rewriteOn);
	modport host (output regWr, regSel, regWdata, cmdValid, cmdErase, cmdAddr, cmdData,
		input cmdBusy, cmdDone, cmdRefused, cmdAborted, modeEw1, rewriteOn);
endinterface : fcr_if
`default_nettype wire

// ### shared/fcr_pkg.sv
// Overview of operation
// - Area one blocks lockable against program/erase.
// - Both program areas rewritable, three paths.
// - Area two usable only while disable bit 0.
// - Map bit 1 puts data flash at E000-FFFF.
// - Data flash is blocks A and B.
// - Controller slows clock, sets wait before rewrite.
// - RAM-executing mode forbids flash-reading trap instructions.
// - RAM-executing mode needs vectors moved to RAM.
// - RAM mode: NMI or watchdog resets mode registers.
// - No address match; rerun after halt.
// - Flash mode: hold interrupts during auto operation.
// - Flash mode: NMI resets mode registers, stops.
// - Flash mode: watchdog frozen during auto operation.
// - Enable bit takes 1 only after 0.
// - Never rewrite the block holding the program.
//
// Purpose: Shared constants for the flash rewrite controller and its host.
// Assumes: One clock, mclk at 25 MHz, synchronous active-low reset.
// Notes: Block indices 0-7 are area one, 8 area two, 9 and 10 data flash.
package fcr_pkg;
	localparam int NUM_BLK = 11;
	localparam int AREA1_BLKS = 8;
	localparam int WORDS_PER_BLK = 16;
	localparam int NUM_WORDS = NUM_BLK * WORDS_PER_BLK;
	localparam logic [3:0] BLK_AREA2 = 4'h8;
	localparam logic [3:0] BLK_DATA_A = 4'h9;
	localparam logic [3:0] BLK_DATA_B = 4'ha;
	localparam logic [15:0] DATA_BASE = 16'he000;
	localparam logic [3:0] AREA2_PAGE = 4'h1;
	// Register selects on the link.
	localparam logic [2:0] SEL_FLASH_MODE_REG_ZERO = 3'h0;
	localparam logic [2:0] SEL_FLASH_MODE_REG_ONE = 3'h1;
	localparam logic [2:0] SEL_PM1 = 3'h2;
	localparam logic [2:0] SEL_CM = 3'h3;
	localparam logic [2:0] SEL_SECOND_AREA_CONTROL_REG = 3'h4;
	localparam logic [2:0] SEL_LOCK = 3'h5;
	// Field positions.
	localparam int ENA_BIT = 1;
	localparam int ENB_BIT = 2;
	localparam int EW1_BIT = 1;
	localparam int MAP_BIT = 0;
	localparam int WAIT_BIT = 7;
	localparam int DIS_BIT = 0;
	// Values after reset.
	localparam logic [7:0] SECOND_AREA_CONTROL_REG_RST = 8'h01;
	localparam logic [7:0] LOCK_RST = 8'h00;
	localparam logic [7:0] CM_RST = 8'h00;
	// Divider code giving mclk/4, 6.25 MHz, under the 10 MHz limit.
	localparam logic [7:0] CLK_DIV_SAFE = 8'h06;
	localparam int CPU_CLK_MAX_MHZ = 10;
	localparam int MCLK_MHZ = 25;
	// Auto operation lengths in mclk cycles.
	localparam logic [7:0] PROG_CYCLES = 8'd20;
	localparam logic [7:0] ERASE_CYCLES = 8'd40;
	// Host register offsets.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR = 8'h04;
	localparam logic [7:0] OFS_DATA = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0c;
	localparam logic [7:0] OFS_MAP = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {FCR_SRC_CPU, FCR_SRC_SERIAL, FCR_SRC_PARALLEL} fcr_src_t;
endpackage : fcr_pkg

// ### testbench/fcr_link_sva.sv
// Purpose: Concurrent checks on the link between rewrite host and flash device.
// Assumes: One mclk domain, rst_n synchronous and active low.
// Notes: Operation length allows one cycle of slack either way.
`timescale 1ns/1ps
`default_nettype none
module fcr_link_sva
	import fcr_pkg::*;
#(
	parameter logic [3:0] SELF_PAGE = 4'hf
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic regWr,
	input wire logic [2:0] regSel,
	input wire logic [7:0] regWdata,
	input wire logic cmdValid,
	input wire logic cmdErase,
	input wire logic [15:0] cmdAddr,
	input wire logic cmdBusy,
	input wire logic cmdDone,
	input wire logic cmdRefused,
	input wire logic cmdAborted,
	input wire logic modeEw1,
	input wire logic rewriteOn
);
	logic armA_reg, clkOk_reg, waitOk_reg, lnkOp_reg, eraseOp_reg;
	logic [7:0] busyCnt_reg;
	logic [7:0] lim;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// A written 0 arms enable bit a; an abort disarms it as the device does.
	always_ff @(posedge mclk) begin
		if (!rst_n || cmdAborted) armA_reg <= 1'b0;
		else if (regWr && regSel == SEL_FLASH_MODE_REG_ZERO) armA_reg <= !regWdata[ENA_BIT];
	end
	// Last divider and wait settings written over the link.
	always_ff @(posedge mclk) begin
		if (!rst_n) clkOk_reg <= 1'b0;
		else if (regWr && regSel == SEL_CM) clkOk_reg <= regWdata == CLK_DIV_SAFE;
		if (!rst_n) waitOk_reg <= 1'b0;
		else if (regWr && regSel == SEL_PM1) waitOk_reg <= regWdata[WAIT_BIT];
	end
	// Only link commands are timed, since side-port commands carry no kind here.
	always_ff @(posedge mclk) begin
		if (!rst_n || cmdDone || cmdRefused || cmdAborted) lnkOp_reg <= 1'b0;
		else if (cmdValid && !cmdBusy) lnkOp_reg <= 1'b1;
		if (!rst_n) eraseOp_reg <= 1'b0;
		else if (cmdValid) eraseOp_reg <= cmdErase;
		if (!rst_n || cmdValid) busyCnt_reg <= 8'h00;
		else if (cmdBusy && busyCnt_reg != 8'hff) busyCnt_reg <= busyCnt_reg + 8'h01;
	end
	assign lim = eraseOp_reg ? ERASE_CYCLES : PROG_CYCLES;
	cmd_answer_a: assert property (cmdValid && !cmdBusy && rewriteOn |=> cmdRefused != cmdBusy)
		else $error("command not answered once");
	refuse_idle_a: assert property (cmdRefused |-> !cmdBusy && !cmdDone)
		else $error("refusal while busy");
	op_time_a: assert property (cmdDone && lnkOp_reg
		|-> busyCnt_reg + 8'h01 >= lim && busyCnt_reg <= lim + 8'h01) else $error("bad op length");
	enable_order_a: assert property ($rose(rewriteOn) |-> $past(armA_reg))
		else $error("enable set without prior 0");
	abort_clear_a: assert property (cmdAborted |-> ##[0:1] (!rewriteOn && !modeEw1 && !cmdBusy))
		else $error("abort left mode bits");
	setup_first_a: assert property (regWr && regSel == SEL_FLASH_MODE_REG_ZERO && regWdata[ENA_BIT]
		|-> clkOk_reg && waitOk_reg) else $error("enable before clock setup");
	enabled_cmd_a: assert property (cmdValid |-> rewriteOn)
		else $error("command while disabled");
	self_block_a: assert property (cmdValid && modeEw1 |-> cmdAddr[15:12] != SELF_PAGE)
		else $error("own block rewritten");
	cover property (cmdDone && eraseOp_reg);
	cover property (cmdRefused);
	cover property (cmdAborted);
endmodule : fcr_link_sva
`default_nettype wire

// ### testbench/tb.sv
// Purpose: Self-checking bench for the rewrite host and flash device pair.
// Assumes: mclk at 25 MHz; both ends joined by one fcr_if.
// Notes: AXI answers are queued by the master tasks and judged by a monitor.
`timescale 1ns/1ps
`default_nettype none
module tb
	import fcr_pkg::*;
;
	logic mclk, rst_n, awvalid, wvalid, bready, arvalid, rready, isrActive, awready, wready;
	logic bvalid, arready, rvalid, irqHold, nmiPin, wdtEvent, extValid, extErase, wdtFreeze;
	logic dataMapped, area2On, memWait, dmaHold, fetchGuard, rdHit;
	logic [7:0] awaddr, araddr, rdData, extData, r;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp, bootSrc;
	logic [15:0] rdAddr, extAddr;
	int fail_count, checks;
	logic [1:0] expB[$];
	logic [65:0] expR[$];
	fcr_if lnk(.mclk(mclk));
	fcr_device fcr_device_inst(.mclk(mclk), .rst_n(rst_n), .lnk(lnk), .nmiPin(nmiPin),
		.wdtEvent(wdtEvent), .bootSrc(bootSrc), .extValid(extValid), .extErase(extErase),
		.extAddr(extAddr), .extData(extData), .rdAddr(rdAddr), .rdData(rdData), .rdHit(rdHit),
		.wdtFreeze(wdtFreeze), .dataMapped(dataMapped), .area2On(area2On), .memWait(memWait));
	fcr_host #(.SELF_PAGE(4'hf)) fcr_host_inst(.mclk(mclk), .rst_n(rst_n), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .isrActive(isrActive), .irqHold(irqHold), .dmaHold(dmaHold),
		.fetchGuard(fetchGuard), .lnk(lnk));
	fcr_link_sva #(.SELF_PAGE(4'hf)) fcr_link_sva_inst(.mclk(mclk), .rst_n(rst_n),
		.regWr(lnk.regWr), .regSel(lnk.regSel), .regWdata(lnk.regWdata),
		.cmdValid(lnk.cmdValid), .cmdErase(lnk.cmdErase), .cmdAddr(lnk.cmdAddr),
		.cmdBusy(lnk.cmdBusy), .cmdDone(lnk.cmdDone), .cmdRefused(lnk.cmdRefused),
		.cmdAborted(lnk.cmdAborted), .modeEw1(lnk.modeEw1), .rewriteOn(lnk.rewriteOn));
	// Free-running system clock.
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic check(input logic [33:0] s, input logic [33:0] e);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value at %0t: saw %h, wanted %h", $time, s, e);
		end
	endtask : check
	task automatic close_out;
		$display("checks %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	// AXI write: both channels offered together, each dropped once taken.
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic fin;
		fin = 1'b0;
		expB.push_back(er);
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!fin) begin
			@(posedge mclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) bready <= 1'b0;
			fin = bvalid && bready;
		end
	endtask : axw
	// AXI read; the mask hides bits whose value is not specified.
	task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic [1:0] er);
		logic fin;
		fin = 1'b0;
		expR.push_back({er, m, d});
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!fin) begin
			@(posedge mclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) rready <= 1'b0;
			fin = rvalid && rready;
		end
	endtask : axr
	// Waits for the device to settle a command; host refusals never reach it.
	task automatic waitEnd;
		int n;
		n = 0;
		while (!(lnk.cmdDone || lnk.cmdRefused) && n < 300) begin
			@(posedge mclk);
			n++;
		end
		repeat (8) @(posedge mclk);
	endtask : waitEnd
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge mclk);
		rdAddr <= a;
		repeat (3) @(posedge mclk);
		check({26'h0, rdData}, {26'h0, e});
		check({33'h0, rdHit}, 34'h1);
	endtask : rd
	task automatic mapw(input logic [31:0] d);
		axw(OFS_MAP, d, RESP_OKAY);
		repeat (10) @(posedge mclk);
	endtask : mapw
	// One rewrite; ev 1 pulses the NMI pin, ev 2 the watchdog, ab times mid-operation.
	task automatic op(input logic [15:0] a, input logic [7:0] d, input logic [3:0] c,
		input int ev, input int ab, input logic [3:0] es);
		int n;
		axw(OFS_DATA, {24'h0, d}, RESP_OKAY);
		axw(OFS_ADDR, {16'h0, a}, RESP_OKAY);
		axw(OFS_CTRL, {28'h0, c}, RESP_OKAY);
		for (int i = 0; i < ab; i++) begin
			n = 0;
			while (!lnk.cmdBusy && n < 400) begin
				@(posedge mclk);
				n++;
			end
			repeat (4) @(posedge mclk);
			check({33'h0, wdtFreeze}, {33'h0, c[2]});
			if (c[2]) check({33'h0, irqHold}, 34'h1);
			check({33'h0, fetchGuard}, {33'h0, !c[2]});
			check({33'h0, dmaHold}, 34'h0);
			nmiPin <= ev == 1;
			wdtEvent <= ev == 2;
			@(posedge mclk);
			wdtEvent <= 1'b0;
			@(posedge mclk);
			nmiPin <= 1'b0;
			isrActive <= 1'b1;
			repeat (8) @(posedge mclk);
			isrActive <= 1'b0;
		end
		waitEnd();
		axr(OFS_STAT, {28'h0, es}, 32'hf, RESP_OKAY);
	endtask : op
	task automatic ext(input logic [15:0] a, input logic er, input logic [7:0] d);
		@(posedge mclk);
		extValid <= 1'b1;
		extErase <= er;
		extAddr <= a;
		extData <= d;
		@(posedge mclk);
		extValid <= 1'b0;
		waitEnd();
	endtask : ext
	// Monitor: each AXI answer is judged against the oldest queued note.
	always @(posedge mclk) begin
		logic [65:0] e;
		if (bvalid && bready && expB.size() > 0)
			check({32'h0, bresp}, {32'h0, expB.pop_front()});
		if (rvalid && rready && expR.size() > 0) begin
			e = expR.pop_front();
			check({rresp, rdata & e[63:32]}, {e[65:64], e[31:0] & e[63:32]});
		end
	end
	// Watchdog against a hung handshake.
	initial begin
		repeat (40000) @(posedge mclk);
		fail_count++;
		close_out();
	end
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, isrActive, nmiPin, wdtEvent} = '0;
		{extValid, extErase, awaddr, araddr, extData, wdata, bootSrc, rdAddr, extAddr} = '0;
		rst_n = 1'b0;
		fail_count = 0;
		checks = 0;
		void'($urandom(56065));
		r = 8'($urandom);
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		check({32'h0, area2On, dataMapped}, 34'h0);
		axr(OFS_DATA, 32'hff, 32'hff, RESP_OKAY);
		axr(8'h14, 32'h0, 32'hffffffff, RESP_SLVERR);
		axw(8'h20, 32'h0, RESP_SLVERR);
		mapw(32'h1);
		check({32'h0, area2On, dataMapped}, 34'h3);
		op(16'he000, 8'hff, 4'hb, 0, 0, 4'h2);
		check({33'h0, memWait}, 34'h1);
		rd(16'he005, 8'hff);
		op(16'he005, r, 4'h9, 0, 0, 4'h2);
		op(16'hf000, 8'hff, 4'hb, 0, 0, 4'h2);
		rd(16'he005, r);
		rd(16'hf003, 8'hff);
		op(16'he000, 8'hff, 4'h3, 0, 0, 4'h4);
		op(16'he000, 8'hff, 4'hb, 1, 1, 4'h2);
		op(16'he000, 8'hff, 4'hb, 2, 2, 4'h8);
		mapw(32'h0);
		op(16'ha000, 8'hff, 4'h7, 2, 1, 4'h2);
		op(16'ha000, 8'hff, 4'h7, 1, 1, 4'h2);
		op(16'ha001, r, 4'h5, 0, 0, 4'h2);
		mapw(32'h400);
		op(16'ha001, 8'h00, 4'h9, 0, 0, 4'h4);
		rd(16'ha001, r);
		op(16'hf000, 8'hff, 4'h7, 0, 0, 4'h4);
		mapw(32'h2);
		check({33'h0, area2On}, 34'h0);
		op(16'h1000, 8'hff, 4'hb, 0, 0, 4'h4);
		mapw(32'h0);
		op(16'h1000, 8'hff, 4'hb, 0, 0, 4'h2);
		rd(16'h1003, 8'hff);
		for (int s = 1; s < 3; s++) begin
			bootSrc <= 2'(s);
			ext(16'hb000, 1'b1, 8'hff);
			ext(16'hb000 + 16'(s), 1'b0, r ^ 8'(s));
			rd(16'hb000 + 16'(s), r ^ 8'(s));
		end
		close_out();
	end
endmodule : tb
`default_nettype wire
